// >>> rtl/ppm_pkg.sv
/*
 Constants, field positions and carrier structs for the port 1 PHY register set.
 Assumes an AHB-Lite master with 32-bit data and one aligned word per register.
*/
// Contract
// - Control bit 4 forces crossed pairing; bit 3 disables automatic crossover.
// - Control bit 2 disables far-end-fault detection in fiber mode.
// - Control bit 1 stops transmit; resets to zero.
// - Status bit 15 always reads zero, no T4 ability.
// - Status bits 14 and 13 read one, 100 Mb/s full and half.
// - Status bits 12 and 11 read one, 10 Mb/s full and half.
// - Status bit 5 shows auto-negotiation complete; zero after reset.
// - Status bit 4 shows far-end fault detected in fiber mode.
// - Status bit 3 reads one, auto-negotiation capable.
// - Status bit 0 reads zero, no extended registers.
// - Two read-only 16-bit identifier words, low and high; writes ignored.
// - Advertise bit 10 writable, resets one, advertises pause ability.
// - Advertise bits 8 and 7 select 100 Mb/s full and half; reset one.
// - Advertise bits 6 and 5 select 10 Mb/s full and half; reset one.
// - Control bit 12 enables auto-negotiation; else forced speed and duplex rule.
// - Forced duplex only with auto-negotiation off; failed negotiation gives half duplex.
package ppm_pkg;
   localparam logic [11:0] PPM_OFF_CTRL = 12'h04C;
   localparam logic [11:0] PPM_OFF_STAT = 12'h04E;
   localparam logic [11:0] PPM_OFF_IDLO = 12'h050;
   localparam logic [11:0] PPM_OFF_IDHI = 12'h052;
   localparam logic [11:0] PPM_OFF_ADV = 12'h054;
   localparam logic [11:0] PPM_OFF_IRQ_STAT = 12'h060;
   localparam logic [11:0] PPM_OFF_IRQ_CLR = 12'h064;
   localparam logic [11:0] PPM_OFF_IRQ_EN = 12'h068;
   // Byte address is four times the printed index
   localparam int PPM_ADDR_W = 14;

   // Control register fields
   localparam int CB_LOOP = 14;
   localparam int CB_F100 = 13;
   localparam int CB_ANEN = 12;
   localparam int CB_PDN = 11;
   localparam int CB_RSTAN = 9;
   localparam int CB_FFD = 8;
   localparam int CB_HPMDIX = 5;
   localparam int CB_FMDIX = 4;
   localparam int CB_DMDIX = 3;
   localparam int CB_DFEF = 2;
   localparam int CB_DTX = 1;
   localparam int CB_RSV0 = 0;
   localparam logic [15:0] PPM_CTRL_RST = 16'h3120;
   // Bit 9 is writable too; the restart handshake clears it again
   localparam logic [15:0] PPM_CTRL_WMASK = 16'h7B3F;

   // Status register: fixed part carries the capability bits
   localparam logic [15:0] PPM_STAT_FIXED = 16'h7808;
   localparam int SB_ANDONE = 5;
   localparam int SB_FEF = 4;
   localparam int SB_LINK = 2;

   localparam logic [15:0] PPM_ADV_RST = 16'h05E1;
   localparam logic [15:0] PPM_ADV_WMASK = 16'h07E0;
   localparam logic [15:0] PPM_ADV_SEL = 16'h0001;

   // Arbitrary identifier defaults
   localparam logic [15:0] PPM_ID_LO_DEF = 16'hA5A5;
   localparam logic [15:0] PPM_ID_HI_DEF = 16'h5A5A;

   // Interrupt event bits
   localparam int EV_LINK_CHG = 0;
   localparam int EV_AN_DONE = 1;
   localparam int EV_FEF = 2;
   localparam int PPM_NEV = 3;

   typedef struct packed {
      logic link_up;
      logic an_done;
      logic an_ok;
      logic far_end_fault;
   } ppm_phy_stat_t;

   typedef struct packed {
      logic force_mdix;
      logic auto_mdix_off;
      logic hp_mdix;
      logic fef_detect_off;
      logic tx_disable;
      logic power_down;
      logic far_loopback;
      logic an_enable;
      logic an_restart;
      logic speed_100;
      logic full_duplex;
      logic adv_pause;
      logic [3:0] adv_abil;
   } ppm_phy_ctrl_t;
endpackage

// >>> rtl/ppm_regs.sv
/*
 Port 1 PHY register set: AHB-Lite slave, PHY control outputs, status inputs, interrupt.
 Assumes PHY status arrives asynchronously and the bus runs on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_regs #(
   parameter logic [15:0] ID_LOW = ppm_pkg::PPM_ID_LO_DEF,
   parameter logic [15:0] ID_HIGH = ppm_pkg::PPM_ID_HI_DEF
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire ppm_pkg::ppm_phy_stat_t phy_stat,
   output ppm_pkg::ppm_phy_ctrl_t phy_ctrl,
   output logic irq
);
   import ppm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // Register index must match the 12-bit offset constants
   if (PPM_ADDR_W - 2 != 12) begin : g_bad_addr_w
      $error("ppm_regs: register index must be 12 bits wide");
   end
   // Event bits share one 16-bit read word with nothing else
   if (PPM_NEV > 16) begin : g_bad_nev
      $error("ppm_regs: too many interrupt events");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status pins synchronised: three stages, change accepted when 2 and 3 agree
   logic [3:0] s1_reg, s2_reg, s3_reg, st_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
      end else begin
         s1_reg <= phy_stat;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               st_reg[i] <= s3_reg[i];
            end
         end
      end
   end
   ppm_phy_stat_t st;
   assign st = ppm_phy_stat_t'(st_reg);

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture; zero wait states
   // Reads are answered from the address phase, so only writes need a flag
   logic wr_reg;
   logic [11:0] a_reg;
   logic take;
   assign take = hsel && hready && htrans[1];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= 1'b0;
         a_reg <= 12'h000;
      end else begin
         wr_reg <= take && hwrite;
         a_reg <= haddr[PPM_ADDR_W-1:2];
      end
   end

   function automatic logic hit(input logic [11:0] idx, input logic [11:0] off);
      hit = (idx == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control and advertisement registers
   logic [15:0] ctrl_reg, adv_reg;
   logic [15:0] wd;
   assign wd = hwdata[15:0];
   // Restart handshake states
   typedef enum logic [2:0] {
      RS_IDLE = 3'b001,
      RS_WAIT = 3'b010,
      RS_DROP = 3'b100
   } ppm_rs_t;
   ppm_rs_t rs_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= PPM_CTRL_RST;
      end else if (wr_reg && hit(a_reg, PPM_OFF_CTRL)) begin
         ctrl_reg <= wd & PPM_CTRL_WMASK;
      end else begin
         // Restart self-clears once negotiation is seen to be running again
         if (rs_reg == RS_WAIT && !st.an_done) begin
            ctrl_reg[CB_RSTAN] <= 1'b0;
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         adv_reg <= PPM_ADV_RST;
      end else if (wr_reg && hit(a_reg, PPM_OFF_ADV)) begin
         adv_reg <= (wd & PPM_ADV_WMASK) | PPM_ADV_SEL;
      end
   end

   // Restart is held until the PHY drops completion, so a restart issued
   // while negotiation is already done is never lost
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rs_reg <= RS_IDLE;
      end else begin
         case (rs_reg)
            RS_IDLE: begin
               if (ctrl_reg[CB_RSTAN]) begin
                  rs_reg <= RS_WAIT;
               end
            end
            RS_WAIT: begin
               if (!ctrl_reg[CB_RSTAN]) begin
                  rs_reg <= RS_IDLE;
               end else if (!st.an_done) begin
                  rs_reg <= RS_DROP;
               end
            end
            RS_DROP: begin
               rs_reg <= RS_IDLE;
            end
            default: begin
               rs_reg <= RS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to the PHY, all registered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phy_ctrl <= '0;
      end else begin
         phy_ctrl.force_mdix <= ctrl_reg[CB_FMDIX];
         phy_ctrl.auto_mdix_off <= ctrl_reg[CB_DMDIX];
         phy_ctrl.hp_mdix <= ctrl_reg[CB_HPMDIX];
         phy_ctrl.fef_detect_off <= ctrl_reg[CB_DFEF];
         phy_ctrl.tx_disable <= ctrl_reg[CB_DTX];
         phy_ctrl.power_down <= ctrl_reg[CB_PDN];
         phy_ctrl.far_loopback <= ctrl_reg[CB_LOOP];
         phy_ctrl.an_enable <= ctrl_reg[CB_ANEN];
         phy_ctrl.an_restart <= ctrl_reg[CB_RSTAN];
         // Forced speed only without negotiation
         phy_ctrl.speed_100 <= ctrl_reg[CB_ANEN] ? 1'b1 : ctrl_reg[CB_F100];
         // Failed negotiation drops to half duplex
         phy_ctrl.full_duplex <= ctrl_reg[CB_ANEN] ? (st.an_done && st.an_ok)
                                                   : ctrl_reg[CB_FFD];
         phy_ctrl.adv_pause <= adv_reg[10];
         phy_ctrl.adv_abil <= adv_reg[8:5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: events are edges of synchronised status
   logic [3:0] prev_reg;
   logic [PPM_NEV-1:0] ev, ist_reg, ien_reg, clr;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= 4'h0;
      end else begin
         prev_reg <= st_reg;
      end
   end
   ppm_phy_stat_t pv;
   assign pv = ppm_phy_stat_t'(prev_reg);
   assign ev[EV_LINK_CHG] = st.link_up ^ pv.link_up;
   assign ev[EV_AN_DONE] = st.an_done && !pv.an_done;
   assign ev[EV_FEF] = st.far_end_fault && !pv.far_end_fault && !ctrl_reg[CB_DFEF];
   assign clr = (wr_reg && hit(a_reg, PPM_OFF_IRQ_CLR)) ? hwdata[PPM_NEV-1:0] : '0;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ist_reg <= '0;
      end else begin
         // Set wins over a simultaneous clear
         ist_reg <= (ist_reg & ~clr) | ev;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ien_reg <= '0;
      end else if (wr_reg && hit(a_reg, PPM_OFF_IRQ_EN)) begin
         ien_reg <= hwdata[PPM_NEV-1:0];
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((ist_reg & ~clr) | ev) & ien_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [15:0] stat_v;
   always_comb begin
      stat_v = PPM_STAT_FIXED;
      stat_v[SB_ANDONE] = st.an_done;
      stat_v[SB_FEF] = st.far_end_fault && !ctrl_reg[CB_DFEF];
      stat_v[SB_LINK] = st.link_up;
   end
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (take && !hwrite) begin
         case (haddr[PPM_ADDR_W-1:2])
            PPM_OFF_CTRL: rd_next = {16'h0000, ctrl_reg};
            PPM_OFF_STAT: rd_next = {16'h0000, stat_v};
            PPM_OFF_IDLO: rd_next = {16'h0000, ID_LOW};
            PPM_OFF_IDHI: rd_next = {16'h0000, ID_HIGH};
            PPM_OFF_ADV: rd_next = {16'h0000, adv_reg};
            PPM_OFF_IRQ_STAT: rd_next = {29'h0, ist_reg};
            PPM_OFF_IRQ_EN: rd_next = {29'h0, ien_reg};
            default: rd_next = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rd_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> bench/ppm_regs_assertions.sv
/*
 Port checker for ppm_regs.
 Assumes single transfers and no two control or advert writes in a row.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_assertions #(
   parameter logic [15:0] ID_LOW = 16'h0000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire ppm_pkg::ppm_phy_stat_t phy_stat,
   input wire ppm_pkg::ppm_phy_ctrl_t phy_ctrl,
   input wire logic irq
);
   import ppm_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [3:0] calm_reg;
   // Status pins pass a synchroniser, so judge them only once settled
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         calm_reg <= 4'h0;
      end else begin
         calm_reg <= $stable(phy_stat) ? calm_reg + {3'h0, calm_reg != 4'hF} : 4'h0;
      end
   end
   sequence s_take(logic [13:0] a, logic w);
      hsel && hready && htrans[1] && hwrite == w && haddr[13:0] == a;
   endsequence
   property p_ctrl;
      logic [3:0] d;
      s_take(14'h0130, 1'b1) ##1 (1'b1, d = hwdata[4:1]) |-> ##2
         {phy_ctrl.force_mdix, phy_ctrl.auto_mdix_off, phy_ctrl.fef_detect_off,
          phy_ctrl.tx_disable} == d;
   endproperty
   property p_adv;
      logic [4:0] d;
      s_take(14'h0150, 1'b1) ##1 (1'b1, d = {hwdata[10], hwdata[8:5]}) |-> ##2
         {phy_ctrl.adv_pause, phy_ctrl.adv_abil} == d;
   endproperty
   ////////////////////////////////////////
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_ctrl_pins: assert property (p_ctrl) else $error("control pins wrong");
   a_adv_pins: assert property (p_adv) else $error("advert pins wrong");
   a_stat_caps: assert property (s_take(14'h0138, 1'b0) |=>
      hrdata[15:11] == 5'h0F && hrdata[3] && !hrdata[0]) else $error("capability bits wrong");
   a_ident_low: assert property (s_take(14'h0140, 1'b0) |=> hrdata == {16'h0000, ID_LOW})
      else $error("identifier wrong");
   a_sel_fixed: assert property (s_take(14'h0150, 1'b0) |=>
      hrdata[4:0] == 5'h01 && hrdata[31:11] == 21'h0) else $error("selector wrong");
   a_link_shown: assert property (s_take(14'h0138, 1'b0) && calm_reg == 4'hF |=>
      hrdata[2] == $past(phy_stat.link_up) && hrdata[5] == $past(phy_stat.an_done))
      else $error("link or negotiation bit wrong");
   a_fail_half: assert property (phy_ctrl.an_enable && calm_reg == 4'hF && !phy_stat.an_ok
      |-> !phy_ctrl.full_duplex) else $error("failed negotiation not half duplex");
   a_unmapped_zero: assert property (s_take(14'h01F0, 1'b0) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind ppm_regs ppm_regs_assertions #(.ID_LOW(ID_LOW)) ppm_regs_assertions_inst (
   .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .phy_stat(phy_stat), .phy_ctrl(phy_ctrl), .irq(irq)
);
`default_nettype wire

// >>> bench/ppm_phy_model.sv
/*
 Behavioural PHY and negotiation partner for ppm_regs.
 Assumes the bench drives cable, fault and peer ability levels.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_phy_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire ppm_pkg::ppm_phy_ctrl_t phy_ctrl,
   input wire logic plug,
   input wire logic fault,
   input wire logic peer_ok,
   output ppm_pkg::ppm_phy_stat_t phy_stat
);
   import ppm_pkg::*;
   logic [3:0] an_cnt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phy_stat <= '0;
         an_cnt <= 4'h0;
      end else begin
         phy_stat.link_up <= plug && !phy_ctrl.tx_disable;
         // Restart drops completion so the register can self-clear
         an_cnt <= (phy_stat.link_up && phy_ctrl.an_enable && !phy_ctrl.an_restart) ?
            an_cnt + {3'h0, an_cnt != 4'hF} : 4'h0;
         phy_stat.an_done <= an_cnt == 4'hF;
         phy_stat.an_ok <= peer_ok;
         phy_stat.far_end_fault <= fault && !phy_ctrl.fef_detect_off;
      end
   end
endmodule
`default_nettype wire

// >>> bench/port_phy_mii_register_set_test.sv
/*
 Self-checking bench for ppm_regs over AHB-Lite.
 Assumes the PHY model beside it and hready fed from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module port_phy_mii_register_set_test;
   import ppm_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic plug = 1'b0, fault = 1'b0, peer_ok = 1'b1, hreadyout, hresp, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   ppm_phy_stat_t phy_stat;
   ppm_phy_ctrl_t phy_ctrl;
   int bad_count = 0, compares = 0;
   always #2 clock = ~clock;
   ppm_regs ppm_regs_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy_stat(phy_stat),
      .phy_ctrl(phy_ctrl), .irq(irq));
   ppm_phy_model ppm_phy_model_inst (.clock(clock), .rst_n(rst_n), .phy_ctrl(phy_ctrl),
      .plug(plug), .fault(fault), .peer_ok(peer_ok), .phy_stat(phy_stat));
   ////////////////////////////////////////
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      ck(n, e, rd);
   endtask
   task automatic test_done;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rc("ctrl", 32'h130, 32'h3120);
      rc("stat", 32'h138, 32'h7808);
      rc("idlo", 32'h140, {16'h0, PPM_ID_LO_DEF});
      rc("idhi", 32'h148, {16'h0, PPM_ID_HI_DEF});
      rc("adv", 32'h150, 32'h05E1);
      ck("ctrl_misc", 32'h8, {28'h0, phy_ctrl.hp_mdix, phy_ctrl.power_down,
         phy_ctrl.far_loopback, phy_ctrl.an_restart});
      for (int b = 1; b < 5; b++) begin
         bus(1'b1, 32'h130, 32'h3120 | (32'h1 << b));
         rc("ctrl_wr", 32'h130, 32'h3120 | (32'h1 << b));
         ck("ctrl_pin", 32'h1 << (b - 1), {28'h0, phy_ctrl.force_mdix,
            phy_ctrl.auto_mdix_off, phy_ctrl.fef_detect_off, phy_ctrl.tx_disable});
      end
      bus(1'b1, 32'h138, 32'hFFFF);
      bus(1'b1, 32'h140, 32'h0);
      rc("stat_ro", 32'h138, 32'h7808);
      rc("idlo_ro", 32'h140, {16'h0, PPM_ID_LO_DEF});
      rc("unmapped", 32'h1F0, 32'h0);
      for (int v = 0; v < 2; v++) begin
         bus(1'b1, 32'h150, v ? 32'hFFFF : 32'h0);
         rc("adv_wr", 32'h150, v ? 32'h07E1 : 32'h1);
         ck("adv_pin", v ? 32'h1F : 32'h0, {27'h0, phy_ctrl.adv_pause, phy_ctrl.adv_abil});
      end
      bus(1'b1, 32'h130, 32'h3120);
      bus(1'b1, 32'h1A0, 32'h7);
      plug <= 1'b1;
      repeat (40) @(posedge clock);
      rc("link", 32'h138, 32'h782C);
      ck("duplex", 32'h1, {31'h0, phy_ctrl.full_duplex});
      ck("irq_on", 32'h1, {31'h0, irq});
      rc("ev", 32'h180, 32'h3);
      bus(1'b1, 32'h190, 32'h3);
      rc("ev_clr", 32'h180, 32'h0);
      ck("irq_off", 32'h0, {31'h0, irq});
      fault <= 1'b1;
      repeat (10) @(posedge clock);
      rc("fef", 32'h138, 32'h783C);
      ck("irq_fef", 32'h1, {31'h0, irq});
      bus(1'b1, 32'h1A0, 32'h0);
      rc("ev_keep", 32'h180, 32'h4);
      ck("irq_mask", 32'h0, {31'h0, irq});
      bus(1'b1, 32'h130, 32'h3124);
      repeat (10) @(posedge clock);
      rc("fef_off", 32'h138, 32'h782C);
      // Peer refuses ability, so a restarted negotiation must end half duplex
      peer_ok <= 1'b0;
      bus(1'b1, 32'h130, 32'h3324);
      rc("restart_set", 32'h130, 32'h3324);
      repeat (40) @(posedge clock);
      rc("restart", 32'h130, 32'h3124);
      ck("half", 32'h0, {31'h0, phy_ctrl.full_duplex});
      bus(1'b1, 32'h130, 32'h2100);
      repeat (3) @(posedge clock);
      ck("forced", 32'h3, {29'h0, phy_ctrl.an_enable, phy_ctrl.speed_100,
         phy_ctrl.full_duplex});
      bus(1'b1, 32'h130, 32'h0);
      repeat (3) @(posedge clock);
      ck("forced", 32'h0, {29'h0, phy_ctrl.an_enable, phy_ctrl.speed_100,
         phy_ctrl.full_duplex});
      test_done();
   end
endmodule
`default_nettype wire
